/* src/alias_pin_params.svh */
`ifndef ALIAS_PIN_PARAMS_SVH
`define ALIAS_PIN_PARAMS_SVH

// register offsets
`define OFS_ALIAS_6 8'h16
`define OFS_ALIAS_7 8'h17
`define OFS_SCRATCH_0 8'h18
`define OFS_SCRATCH_1 8'h19
`define OFS_PIN_CFG 8'h1A

// reset values
`define RST_ALIAS 8'h00
`define RST_SCRATCH_0 8'h00
`define RST_SCRATCH_1 8'h01
`define RST_PIN_CFG 8'h00

// field positions of the pin configuration register
`define PIN_GLB_LEVEL_BIT 7
`define PIN_GLB_DIR_BIT 5
`define PIN_GLB_EN_BIT 4
`define PIN9_LEVEL_BIT 3
`define PIN9_DIR_BIT 1
`define PIN9_EN_BIT 0

// writable mask of alias registers, bit 0 read-only
`define ALIAS_WR_MASK 8'hFE

// count of pins under global force only
`define PIN_COUNT 4

`endif

/* src/alias_pin_pkg.sv */
package alias_pin_pkg;

  // local controller-bus register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // pad decision for one pin
  typedef struct packed {
    logic drive_en;
    logic level;
    logic is_input;
  } pad_ctl_s;

  // pin modes decoded from {dir, en}
  typedef enum logic [3:0] {
    PMODE_FUNC  = 4'h1,
    PMODE_TRI   = 4'h2,
    PMODE_OUT   = 4'h4,
    PMODE_IN    = 4'h8
  } pin_mode_e;

  // address retarget request and answer
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } bus_addr_s;

endpackage

/* src/pin_pad_ctl.sv */
`timescale 1ns/1ps
`include "alias_pin_params.svh"
module pin_pad_ctl
  import alias_pin_pkg::*;
(
  // configuration
  input wire logic gp_dir_in,
  input wire logic gp_en_in,
  input wire logic gp_level_in,
  input wire logic remote_ctl_in,
  input wire logic remote_level_in,
  input wire logic glb_dir_in,
  input wire logic glb_en_in,
  input wire logic glb_level_in,
  input wire logic func_level_in,
  // pad decision
  output pad_ctl_s pad_out
);

  // mode decode of a {dir, en} pair
  function automatic pin_mode_e decode_mode(input logic dir, input logic en);
    unique case ({dir, en})
      2'b00: decode_mode = PMODE_FUNC;
      2'b10: decode_mode = PMODE_TRI;
      2'b01: decode_mode = PMODE_OUT;
      default: decode_mode = PMODE_IN;
    endcase
  endfunction

  pin_mode_e own_mode;
  pin_mode_e glb_mode;

  assign own_mode = decode_mode(gp_dir_in, gp_en_in);
  assign glb_mode = decode_mode(glb_dir_in, glb_en_in);

  // own settings override the global force when not functional
  always_comb begin
    pad_out = '0;
    if (remote_ctl_in && own_mode != PMODE_FUNC && own_mode != PMODE_TRI) begin
      pad_out.drive_en = 1'b1; // remote control owns the pin
      pad_out.level = remote_level_in;
    end else begin
      unique case (own_mode)
        PMODE_OUT: begin
          pad_out.drive_en = 1'b1;
          pad_out.level = gp_level_in;
        end
        PMODE_IN: pad_out.is_input = 1'b1;
        PMODE_TRI: pad_out.drive_en = 1'b0;
        PMODE_FUNC: begin
          unique case (glb_mode)
            PMODE_OUT: begin
              pad_out.drive_en = 1'b1;
              pad_out.level = glb_level_in;
            end
            PMODE_IN: pad_out.is_input = 1'b1;
            PMODE_TRI: pad_out.drive_en = 1'b0;
            PMODE_FUNC: begin
              pad_out.drive_en = 1'b1;
              pad_out.level = func_level_in;
            end
          endcase
        end
      endcase
    end
  end

endmodule

/* src/alias_mailbox_gpio_regs.sv */
// Operation
// - each alias register keeps a 7-bit alias in bits 7..1 used to spot remote-target accesses.
// - a matching access is forwarded with its address replaced by the paired remote target address.
// - an alias of zero never matches, so nothing is forwarded through that entry.
// - bit 0 of each alias register is read-only and reads zero.
// - the global level drives every non-individually-enabled pin when global force output is set.
// - global {dir, en} selects 00 functional, 10 tri-state, 01 forced out, 11 forced in.
// - a pin's own dir/en settings other than 00 functional win over the global force settings.
// - pin 9's own level drives the pin only in its output mode without remote control.
// - pin 9 {dir, en} selects 00 functional, 10 tri-state, 01 output, 11 input.
// - bits 6 and 2 of the pin configuration register are reserved, writable, reset zero.
`timescale 1ns/1ps
`include "alias_pin_params.svh"
module alias_mailbox_gpio_regs
  import alias_pin_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // register access from the local controller-bus slave
  input reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  // controller-bus address decoder
  input bus_addr_s probe_in,
  input wire logic [6:0] remote_target_6_in,
  input wire logic [6:0] remote_target_7_in,
  output bus_addr_s forward_out,
  // pin 9 pad, remote control and functional source
  input wire logic pin9_remote_ctl_in,
  input wire logic pin9_remote_level_in,
  input wire logic pin9_func_level_in,
  input wire logic pin9_pad_in,
  output logic pin9_pad_out,
  output logic pin9_pad_oe_n_out,
  output logic pin9_level_seen_out,
  // other pins under global force only
  input wire logic [`PIN_COUNT-1:0] pins_func_level_in,
  output logic [`PIN_COUNT-1:0] pins_pad_out,
  output logic [`PIN_COUNT-1:0] pins_pad_oe_n_out,
  // exposed configuration
  output logic [6:0] remote_alias_six_out,
  output logic [6:0] remote_alias_seven_out
);

  logic [7:0] alias6_reg, alias6_next;
  logic [7:0] alias7_reg, alias7_next;
  logic [7:0] scratch0_reg, scratch0_next;
  logic [7:0] scratch1_reg, scratch1_next;
  logic [7:0] pincfg_reg, pincfg_next;
  logic [7:0] rdata_reg, rdata_next;
  bus_addr_s fwd_reg, fwd_next;
  logic [2:0] pin9_sync_reg, pin9_sync_next;
  logic pin9_seen_reg, pin9_seen_next;

  logic [6:0] remote_alias_six;
  logic [6:0] remote_alias_seven;
  logic pin9_direction;
  logic pin9_function_select;
  logic pin9_drive_level;
  pad_ctl_s pin9_ctl;
  pad_ctl_s [`PIN_COUNT-1:0] pins_ctl;

  // field views
  assign remote_alias_six = alias6_reg[7:1];
  assign remote_alias_seven = alias7_reg[7:1];
  assign pin9_direction = pincfg_reg[`PIN9_DIR_BIT];
  assign pin9_function_select = pincfg_reg[`PIN9_EN_BIT];
  assign pin9_drive_level = pincfg_reg[`PIN9_LEVEL_BIT];

  // register write next state
  always_comb begin
    alias6_next = alias6_reg;
    alias7_next = alias7_reg;
    scratch0_next = scratch0_reg;
    scratch1_next = scratch1_reg;
    pincfg_next = pincfg_reg;
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        `OFS_ALIAS_6: alias6_next = reg_req_in.wdata & `ALIAS_WR_MASK;
        `OFS_ALIAS_7: alias7_next = reg_req_in.wdata & `ALIAS_WR_MASK;
        `OFS_SCRATCH_0: scratch0_next = reg_req_in.wdata;
        `OFS_SCRATCH_1: scratch1_next = reg_req_in.wdata;
        `OFS_PIN_CFG: pincfg_next = reg_req_in.wdata;
        default: ;
      endcase
    end
  end

  // register storage
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alias6_reg <= `RST_ALIAS;
      alias7_reg <= `RST_ALIAS;
      scratch0_reg <= `RST_SCRATCH_0;
      scratch1_reg <= `RST_SCRATCH_1;
      pincfg_reg <= `RST_PIN_CFG;
    end else begin
      alias6_reg <= alias6_next;
      alias7_reg <= alias7_next;
      scratch0_reg <= scratch0_next;
      scratch1_reg <= scratch1_next;
      pincfg_reg <= pincfg_next;
    end
  end

  // read data, captured on the same edge that samples the read strobe
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        `OFS_ALIAS_6: rdata_next = {alias6_reg[7:1], 1'b0};
        `OFS_ALIAS_7: rdata_next = {alias7_reg[7:1], 1'b0};
        `OFS_SCRATCH_0: rdata_next = scratch0_reg;
        `OFS_SCRATCH_1: rdata_next = scratch1_reg;
        `OFS_PIN_CFG: rdata_next = pincfg_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // alias match and address retarget
  always_comb begin
    fwd_next = '0;
    if (probe_in.valid) begin
      if (remote_alias_six != 7'h00 && probe_in.addr == remote_alias_six) begin
        fwd_next.valid = 1'b1;
        fwd_next.addr = remote_target_6_in;
      end else if (remote_alias_seven != 7'h00 && probe_in.addr == remote_alias_seven) begin
        fwd_next.valid = 1'b1;
        fwd_next.addr = remote_target_7_in;
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fwd_reg <= '0;
    end else begin
      fwd_reg <= fwd_next;
    end
  end

  assign forward_out = fwd_reg;

  // pin 9 pad decision, own settings first
  pin_pad_ctl u_pin9 (
    .gp_dir_in(pin9_direction),
    .gp_en_in(pin9_function_select),
    .gp_level_in(pin9_drive_level),
    .remote_ctl_in(pin9_remote_ctl_in),
    .remote_level_in(pin9_remote_level_in),
    .glb_dir_in(pincfg_reg[`PIN_GLB_DIR_BIT]),
    .glb_en_in(pincfg_reg[`PIN_GLB_EN_BIT]),
    .glb_level_in(pincfg_reg[`PIN_GLB_LEVEL_BIT]),
    .func_level_in(pin9_func_level_in),
    .pad_out(pin9_ctl)
  );

  // other pins follow only the global force
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pins
      pin_pad_ctl u_pin (
        .gp_dir_in(1'b0),
        .gp_en_in(1'b0),
        .gp_level_in(1'b0),
        .remote_ctl_in(1'b0),
        .remote_level_in(1'b0),
        .glb_dir_in(pincfg_reg[`PIN_GLB_DIR_BIT]),
        .glb_en_in(pincfg_reg[`PIN_GLB_EN_BIT]),
        .glb_level_in(pincfg_reg[`PIN_GLB_LEVEL_BIT]),
        .func_level_in(pins_func_level_in[gi]),
        .pad_out(pins_ctl[gi])
      );
      assign pins_pad_out[gi] = pins_ctl[gi].level;
      assign pins_pad_oe_n_out[gi] = ~pins_ctl[gi].drive_en;
    end
  endgenerate

  // pin 9 pad drive, enable active low
  assign pin9_pad_out = pin9_ctl.level;
  assign pin9_pad_oe_n_out = ~pin9_ctl.drive_en;

  // pin 9 input sampling, three flops, change taken when last two agree
  always_comb begin
    pin9_sync_next = {pin9_sync_reg[1:0], pin9_pad_in};
    pin9_seen_next = pin9_seen_reg;
    if (pin9_sync_reg[2] == pin9_sync_reg[1]) begin
      pin9_seen_next = pin9_sync_reg[2];
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin9_sync_reg <= 3'h0;
      pin9_seen_reg <= 1'b0;
    end else begin
      pin9_sync_reg <= pin9_sync_next;
      pin9_seen_reg <= pin9_seen_next;
    end
  end

  assign pin9_level_seen_out = pin9_seen_reg;
  assign remote_alias_six_out = remote_alias_six;
  assign remote_alias_seven_out = remote_alias_seven;

endmodule

/* dv/regs_checker_assertions.sv */
`timescale 1ns/1ps
`include "alias_pin_params.svh"
module regs_checker
  import alias_pin_pkg::*;
(
  // clock, reset and stimulus
  input wire logic clock_in,
  input wire logic nrst_in,
  input reg_req_s reg_req_in,
  input bus_addr_s probe_in,
  input wire logic [6:0] remote_target_6_in,
  input wire logic pin9_remote_ctl_in,
  // observed outputs
  input wire logic [7:0] reg_rdata_out,
  input bus_addr_s forward_out,
  input wire logic pin9_pad_out,
  input wire logic pin9_pad_oe_n_out,
  input wire logic [`PIN_COUNT-1:0] pins_pad_out,
  input wire logic [`PIN_COUNT-1:0] pins_pad_oe_n_out,
  input wire logic [6:0] remote_alias_six_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  logic cfg_wr;
  logic [7:0] wd;
  // write to the pin configuration register
  assign cfg_wr = reg_req_in.wr && reg_req_in.addr == `OFS_PIN_CFG;
  assign wd = reg_req_in.wdata;
  fwd_cause_a: assert property (forward_out.valid |-> $past(probe_in.valid))
    else $error("forward without probe");
  zero_alias_a: assert property (probe_in.valid && probe_in.addr == 7'h00 |=> !forward_out.valid)
    else $error("zero alias matched");
  alias_match_a: assert property (probe_in.valid && probe_in.addr == remote_alias_six_out
    && remote_alias_six_out != 7'h00 |=> forward_out.valid
    && forward_out.addr == $past(remote_target_6_in))
    else $error("alias six not retargeted");
  alias_read_a: assert property (reg_req_in.rd && reg_req_in.addr == `OFS_ALIAS_6
    |=> reg_rdata_out == {$past(remote_alias_six_out), 1'b0})
    else $error("alias read wrong");
  rdata_hold_a: assert property (!reg_req_in.rd |=> $stable(reg_rdata_out))
    else $error("read data moved");
  pin9_drive_a: assert property (cfg_wr && wd[1:0] == 2'b01 && !pin9_remote_ctl_in
    |=> !pin9_pad_oe_n_out && pin9_pad_out == $past(wd[3]))
    else $error("pin9 output level wrong");
  pin9_tri_a: assert property (cfg_wr && wd[1:0] == 2'b10 |=> pin9_pad_oe_n_out)
    else $error("pin9 driven in tri-state");
  glb_force_a: assert property (cfg_wr && wd[5:4] == 2'b01 && wd[1:0] == 2'b00
    |=> pins_pad_oe_n_out == '0 && pins_pad_out == {`PIN_COUNT{$past(wd[7])}}
    && pin9_pad_out == $past(wd[7]))
    else $error("global force output wrong");
  glb_tri_a: assert property (cfg_wr && wd[5:4] == 2'b10 |=> &pins_pad_oe_n_out)
    else $error("global tri-state driven");
endmodule
bind alias_mailbox_gpio_regs regs_checker chk (.clock_in(clock_in), .nrst_in(nrst_in),
  .reg_req_in(reg_req_in), .probe_in(probe_in), .remote_target_6_in(remote_target_6_in),
  .pin9_remote_ctl_in(pin9_remote_ctl_in), .reg_rdata_out(reg_rdata_out),
  .forward_out(forward_out), .pin9_pad_out(pin9_pad_out),
  .pin9_pad_oe_n_out(pin9_pad_oe_n_out), .pins_pad_out(pins_pad_out),
  .pins_pad_oe_n_out(pins_pad_oe_n_out), .remote_alias_six_out(remote_alias_six_out));

/* dv/far_pin_model.sv */
`timescale 1ns/1ps
module far_pin_model (
  // pad as driven by the device
  input wire logic pad_level_in,
  input wire logic pad_oe_n_in,
  // level of the outside driver
  input wire logic ext_level_in,
  output logic pad_seen_out
);
  // outside driver only takes the wire while the device lets go
  assign pad_seen_out = pad_oe_n_in ? ext_level_in : pad_level_in;
endmodule

/* dv/tb_alias_mailbox_gpio_regs.sv */
`timescale 1ns/1ps
`include "alias_pin_params.svh"
module tb_alias_mailbox_gpio_regs;
  import alias_pin_pkg::*;
  logic clock_in = 0, nrst_in = 0, rctl = 0, rlvl = 0, f9 = 0, pad9, lvl9, oe9, seen9, ext = 0;
  reg_req_s req = '0;
  bus_addr_s probe = '0, fwd;
  logic [6:0] t6 = 7'h33, t7 = 7'h22;
  logic [6:0] ra6, ra7;
  logic [7:0] rdata;
  logic [3:0] pfn = '0, pout, poe;
  logic [1:0] e;
  int n_mismatch = 0, n_compared = 0;
  alias_mailbox_gpio_regs DUT (.clock_in(clock_in), .nrst_in(nrst_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .probe_in(probe), .remote_target_6_in(t6),
    .remote_target_7_in(t7), .forward_out(fwd), .pin9_remote_ctl_in(rctl),
    .pin9_remote_level_in(rlvl), .pin9_func_level_in(f9), .pin9_pad_in(pad9),
    .pin9_pad_out(lvl9), .pin9_pad_oe_n_out(oe9), .pin9_level_seen_out(seen9),
    .pins_func_level_in(pfn), .pins_pad_out(pout), .pins_pad_oe_n_out(poe),
    .remote_alias_six_out(ra6), .remote_alias_seven_out(ra7));
  far_pin_model far (.pad_level_in(lvl9), .pad_oe_n_in(oe9), .ext_level_in(ext),
    .pad_seen_out(pad9));
  // clock
  always #5 clock_in = ~clock_in;
  task automatic tick;
    @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    tick;
    req = '0;
    tick;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req = '{1'b0, 1'b1, a, 8'h00};
    tick;
    req = '0;
    chk(rdata, exp);
    tick;
  endtask
  task automatic prb(input logic [6:0] a, input logic [7:0] exp);
    probe = '{1'b1, a};
    tick;
    probe = '0;
    chk({fwd.valid, fwd.addr}, exp);
    tick;
  endtask
  // expected {oe_n, level} of a pad from its {dir, en} pair
  function automatic logic [1:0] pad_exp(input logic [1:0] m, input logic lv, input logic fn);
    case (m)
      2'b00: return {1'b0, fn};
      2'b01: return {1'b0, lv};
      default: return 2'b10;
    endcase
  endfunction
  task automatic chk_pad(input logic oe, input logic lv, input logic [1:0] x);
    chk(oe, x[1]);
    if (!x[1]) chk(lv, x[0]);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clock_in);
    #1 nrst_in = 1;
    tick;
    rd(`OFS_ALIAS_6, `RST_ALIAS);
    rd(`OFS_ALIAS_7, `RST_ALIAS);
    rd(`OFS_SCRATCH_0, `RST_SCRATCH_0);
    rd(`OFS_SCRATCH_1, `RST_SCRATCH_1);
    rd(`OFS_PIN_CFG, `RST_PIN_CFG);
    wr(8'h1B, 8'hFF);
    rd(8'h1B, 8'h00);
    wr(`OFS_ALIAS_6, 8'hA5);
    rd(`OFS_ALIAS_6, 8'hA4);
    wr(`OFS_ALIAS_7, 8'hA5);
    prb(7'h52, {1'b1, t6});
    wr(`OFS_ALIAS_7, 8'h23);
    rd(`OFS_ALIAS_7, 8'h22);
    chk(ra7, 7'h11);
    chk(ra6, 7'h52);
    prb(7'h11, {1'b1, t7});
    prb(7'h12, 8'h00);
    wr(`OFS_ALIAS_6, 8'h01);
    chk(ra6, 7'h00);
    prb(7'h00, 8'h00);
    wr(`OFS_SCRATCH_0, 8'h5A);
    wr(`OFS_SCRATCH_1, 8'hC3);
    rd(`OFS_SCRATCH_0, 8'h5A);
    rd(`OFS_SCRATCH_1, 8'hC3);
    wr(`OFS_PIN_CFG, 8'h44);
    rd(`OFS_PIN_CFG, 8'h44);
    // every global and pin 9 mode, with levels varied across passes
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 16; i++) begin
        f9 = j[1];
        pfn = {4{j[1]}} ^ 4'b0110;
        wr(`OFS_PIN_CFG, {j[0], 1'b0, i[3:2], ~j[0], 1'b0, i[1:0]});
        e = (i[1:0] == 2'b00) ? pad_exp(i[3:2], j[0], f9) : pad_exp(i[1:0], ~j[0], 1'b0);
        chk_pad(oe9, lvl9, e);
        for (int k = 0; k < 4; k++) chk_pad(poe[k], pout[k], pad_exp(i[3:2], j[0], pfn[k]));
      end
    end
    wr(`OFS_PIN_CFG, 8'h01);
    rctl = 1;
    rlvl = 1;
    tick;
    chk_pad(oe9, lvl9, 2'b01);
    rctl = 0;
    ext = 1;
    wr(`OFS_PIN_CFG, 8'h03);
    repeat (5) tick;
    chk({oe9, seen9}, 2'b11);
    close_out;
  end
endmodule
